/* File: src/srtc_top.sv */
// Purpose: Seconds counter with trim, alarm and tamper tag behind APB
// Assumes: osc_in is a 32.768 kHz level already synchronous to pclk
// Notes:   pready is always high; every access completes in two cycles
`timescale 1ns/1ps

// Function
// RULE_01: Count seconds in 32 bits from oscillator
// RULE_02: Seconds halves readable, writable at two indices
// RULE_03: Seconds count resets to zero at power-up
// RULE_04: Time-set flag cleared at reset, sticky on write
// RULE_05: Sync busy while update crosses to oscillator
// RULE_06: Software waits for busy clear before writing
// RULE_07: Tamper tag reloads randomly on seconds writes
// RULE_08: At most eight seconds updates per hour
// RULE_09: Alarm time in two halves, reset zero
// RULE_10: Armed alarm fires when count equals alarm
// RULE_11: Alarm requests wake in sleep, on in off
// RULE_12: Software disarms alarm while changing its time
// RULE_13: Correction is signed four-dot-six hertz value
// RULE_14: Correction keeps one-second tick accurate
// RULE_15: Correction writes need unlocked security key
// RULE_16: Counter never stops in any power state
// RULE_17: Alarm flag sticky, write-one clear, masked default
// RULE_18: Trim stretches second in fractional cycle steps
module srtc_top (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Oscillator and power state
    input  wire logic        osc_in,
    input  wire logic        pwr_sleep,
    input  wire logic        pwr_off,
    // Alarm outputs
    output logic             alarm_irq,
    output logic             wake_req,
    output logic             on_req
);
    // ========================================
    // Address decode
    function automatic logic is_idx(input logic [17:0] a,
                                    input logic [15:0] idx);
        is_idx = (a[1:0] == 2'h0) && (a[17:2] == idx);
    endfunction : is_idx

    logic        acc_wr;
    logic        sel_sec;
    logic        sel_tag;
    logic        sel_sech;
    logic        sel_secl;
    logic        sel_almh;
    logic        sel_alml;
    logic        sel_ctl;
    logic        sel_corr;
    logic        sel_ists;
    logic        sel_imsk;
    logic        mapped;

    assign acc_wr   = psel & penable & pwrite;
    assign sel_sec  = is_idx(paddr, srtc_pkg::IDX_SECURITY);
    assign sel_tag  = is_idx(paddr, srtc_pkg::IDX_TAMPER_TAG);
    assign sel_sech = is_idx(paddr, srtc_pkg::IDX_SECS_HIGH);
    assign sel_secl = is_idx(paddr, srtc_pkg::IDX_SECS_LOW);
    assign sel_almh = is_idx(paddr, srtc_pkg::IDX_ALARM_HIGH);
    assign sel_alml = is_idx(paddr, srtc_pkg::IDX_ALARM_LOW);
    assign sel_ctl  = is_idx(paddr, srtc_pkg::IDX_CONTROL);
    assign sel_corr = is_idx(paddr, srtc_pkg::IDX_FREQ_CORR);
    assign sel_ists = is_idx(paddr, srtc_pkg::IDX_INT_STATUS);
    assign sel_imsk = is_idx(paddr, srtc_pkg::IDX_INT_MASK);
    assign mapped   = sel_sec | sel_tag | sel_sech | sel_secl | sel_almh
                    | sel_alml | sel_ctl | sel_corr | sel_ists | sel_imsk;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;

    // ========================================
    // State
    logic [31:0] secs_q;
    logic [31:0] alarm_q;
    logic [15:0] tag_q;
    logic [15:0] lfsr_q;
    logic [9:0]  corr_q;
    logic        unlocked_q;
    logic        time_set_q;
    logic        busy_q;
    logic        arm_q;
    logic        flag_q;
    logic        mask_q;
    logic        hit_q;
    logic        osc_q;
    logic [22:0] acc_q;
    logic [11:0] hour_q;
    logic [3:0]  upd_q;
    logic [31:0] prdata_q;
    logic        wake_q;
    logic        on_q;

    // ========================================
    // Trimmed one-second tick
    // Phase accumulator in 1/64 cycle units: a second ends once
    // 32768 + correction/64 oscillator cycles have been counted, so the
    // fractional part spreads over successive seconds.
    logic        osc_rise;
    logic [22:0] acc_sum;
    logic [22:0] acc_limit;
    logic        tick;
    logic [22:0] acc_d;

    assign osc_rise  = osc_in & ~osc_q;
    assign acc_sum   = acc_q + srtc_pkg::OSC_STEP; // RULE_18
    assign acc_limit = srtc_pkg::NOMINAL_UNITS
                     + {{13{corr_q[9]}}, corr_q}; // RULE_13 RULE_14
    assign tick      = osc_rise & (acc_sum >= acc_limit); // RULE_14
    assign acc_d     = !osc_rise ? acc_q
                     : tick ? acc_sum - acc_limit : acc_sum; // RULE_18

    // ========================================
    // Write qualification
    logic        wr_sech;
    logic        wr_secl;
    logic        wr_secs;
    logic        limit_hit;
    logic        secs_ok;
    logic        hour_end;
    logic        wr_sync;

    assign wr_sech   = acc_wr & sel_sech;
    assign wr_secl   = acc_wr & sel_secl;
    assign wr_secs   = wr_sech | wr_secl;
    assign limit_hit = (upd_q == srtc_pkg::MAX_UPDATES); // RULE_08
    assign secs_ok   = wr_secs & ~limit_hit; // RULE_08
    assign hour_end  = tick & (hour_q == srtc_pkg::HOUR_LAST);
    assign wr_sync   = acc_wr & (sel_sech | sel_secl | sel_almh
                                 | sel_alml | sel_ctl | sel_corr);

    logic [31:0] secs_d;
    assign secs_d = (wr_sech & secs_ok) ? {pwdata[15:0], secs_q[15:0]}
                  : (wr_secl & secs_ok) ? {secs_q[31:16], pwdata[15:0]}
                  : tick ? secs_q + 32'h0000_0001 : secs_q; // RULE_01

    // ========================================
    // Alarm
    logic        hit;
    logic        alarm_rise;
    logic        flag_clr;

    assign hit        = arm_q & (secs_q == alarm_q); // RULE_10
    assign alarm_rise = hit & ~hit_q;
    assign flag_clr   = acc_wr & sel_ists & pwdata[srtc_pkg::BIT_ALARM_FLAG];
    assign alarm_irq  = flag_q & ~mask_q; // RULE_17
    assign wake_req   = wake_q;
    assign on_req     = on_q;

    // ========================================
    // Read mux
    logic [15:0] rd_word;
    logic [15:0] ctl_word;

    assign ctl_word = {time_set_q, busy_q, 3'h0, arm_q, 10'h000};
    assign rd_word  = sel_tag  ? tag_q
                    : sel_sech ? secs_q[31:16]
                    : sel_secl ? secs_q[15:0]
                    : sel_almh ? alarm_q[31:16]
                    : sel_alml ? alarm_q[15:0]
                    : sel_ctl  ? ctl_word
                    : sel_corr ? {6'h00, corr_q}
                    : sel_ists ? {13'h0000, flag_q, 2'h0}
                    : sel_imsk ? {13'h0000, mask_q, 2'h0}
                    : sel_sec  ? {15'h0000, unlocked_q}
                    : 16'h0000;
    assign prdata   = prdata_q;

    // ========================================
    // Counter, trim and tick state
    // Nothing here gates on power state: the count runs always.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secs_q <= srtc_pkg::SECS_RST; // RULE_03
            acc_q  <= 23'h000000;
            osc_q  <= 1'b0;
        end else begin
            secs_q <= secs_d; // RULE_01 RULE_16
            acc_q  <= acc_d;
            osc_q  <= osc_in;
        end
    end

    // ========================================
    // Write limiter and tamper tag
    // Window restarts every hour of trimmed ticks counted from reset
    // Tag samples a free-running generator, never a sequence count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hour_q <= 12'h000;
            upd_q  <= 4'h0;
            tag_q  <= srtc_pkg::TAG_RST;
            lfsr_q <= srtc_pkg::LFSR_SEED;
        end else begin
            if (tick)
                hour_q <= hour_end ? 12'h000 : hour_q + 12'h001;
            if (hour_end)
                upd_q <= 4'h0; // RULE_08
            else if (secs_ok)
                upd_q <= upd_q + 4'h1; // RULE_08
            lfsr_q <= {lfsr_q[14:0],
                       lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
            if (secs_ok)
                tag_q <= lfsr_q; // RULE_07
        end
    end

    // ========================================
    // Software controlled registers
    // Writes apply at once; busy covers the hand-over to the next
    // oscillator edge, where the change becomes visible to the tick.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_q    <= srtc_pkg::ALARM_RST;
            corr_q     <= srtc_pkg::CORR_RST;
            unlocked_q <= 1'b0;
            time_set_q <= 1'b0;
            busy_q     <= 1'b0;
            arm_q      <= 1'b0;
            mask_q     <= srtc_pkg::MASK_RST;
        end else begin
            if (acc_wr & sel_almh)
                alarm_q[31:16] <= pwdata[15:0]; // RULE_09
            if (acc_wr & sel_alml)
                alarm_q[15:0] <= pwdata[15:0]; // RULE_09
            if (acc_wr & sel_ctl)
                arm_q <= pwdata[srtc_pkg::BIT_ALARM_ARM];
            if (acc_wr & sel_imsk)
                mask_q <= pwdata[srtc_pkg::BIT_ALARM_FLAG];
            if (acc_wr & sel_sec)
                unlocked_q <= (pwdata[15:0] == srtc_pkg::UNLOCK_CODE);
            if (acc_wr & sel_corr & unlocked_q)
                corr_q <= pwdata[9:0]; // RULE_15
            if (wr_secs)
                time_set_q <= 1'b1; // RULE_04
            if (wr_sync)
                busy_q <= 1'b1; // RULE_05
            else if (osc_rise)
                busy_q <= 1'b0; // RULE_05
        end
    end

    // ========================================
    // Alarm flag, requests and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q   <= 1'b0;
            hit_q    <= 1'b0;
            wake_q   <= 1'b0;
            on_q     <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            hit_q  <= hit;
            // Set wins over a simultaneous write-one clear
            flag_q <= alarm_rise | (flag_q & ~flag_clr); // RULE_17
            wake_q <= alarm_rise & pwr_sleep; // RULE_11
            on_q   <= alarm_rise & pwr_off; // RULE_11
            if (psel & ~penable)
                prdata_q <= {16'h0000, rd_word}; // RULE_02
        end
    end

    // ========================================
    // Checks
    time_step_a: assert property ( // RULE_01
        @(posedge pclk) disable iff (!presetn)
        tick & ~wr_secs |=> secs_q == $past(secs_q) + 32'h0000_0001)
        else $error("seconds did not step on tick");

    idle_hold_a: assert property ( // RULE_16
        @(posedge pclk) disable iff (!presetn)
        ~tick & ~wr_secs |=> $stable(secs_q))
        else $error("seconds moved without tick or write");

    set_sticky_a: assert property ( // RULE_04
        @(posedge pclk) disable iff (!presetn)
        wr_secs |=> time_set_q [*4])
        else $error("time-set flag not sticky");

    busy_flag_a: assert property ( // RULE_05
        @(posedge pclk) disable iff (!presetn)
        wr_sync |=> busy_q)
        else $error("busy not raised by register write");

    busy_clear_a: assert property ( // RULE_05
        @(posedge pclk) disable iff (!presetn)
        osc_rise & ~wr_sync |=> ~busy_q)
        else $error("busy not cleared on oscillator edge");

    tag_load_a: assert property ( // RULE_07
        @(posedge pclk) disable iff (!presetn)
        secs_ok |=> tag_q == $past(lfsr_q))
        else $error("tamper tag not reloaded");

    write_limit_a: assert property ( // RULE_08
        @(posedge pclk) disable iff (!presetn)
        wr_secs & limit_hit & ~tick |=> $stable(secs_q) && $stable(tag_q))
        else $error("write accepted past hourly limit");

    update_cap_a: assert property ( // RULE_08
        @(posedge pclk) disable iff (!presetn)
        upd_q <= srtc_pkg::MAX_UPDATES)
        else $error("hourly update count past its limit");

    alarm_arm_a: assert property ( // RULE_10
        @(posedge pclk) disable iff (!presetn)
        ~arm_q & ~flag_q & ~flag_clr |=> ~flag_q)
        else $error("alarm flag set while disarmed");

    alarm_fire_a: assert property ( // RULE_10
        @(posedge pclk) disable iff (!presetn)
        hit & ~hit_q |=> flag_q)
        else $error("armed match did not set flag");

    wake_req_a: assert property ( // RULE_11
        @(posedge pclk) disable iff (!presetn)
        alarm_rise & pwr_sleep |=> wake_req ##1 ~wake_req)
        else $error("wake request not one pulse");

    on_req_a: assert property ( // RULE_11
        @(posedge pclk) disable iff (!presetn)
        alarm_rise & pwr_off |=> on_req ##1 ~on_req)
        else $error("on request not one pulse");

    trim_lock_a: assert property ( // RULE_15
        @(posedge pclk) disable iff (!presetn)
        acc_wr & sel_corr & ~unlocked_q |=> $stable(corr_q))
        else $error("correction written while locked");

    flag_clear_a: assert property ( // RULE_17
        @(posedge pclk) disable iff (!presetn)
        flag_clr & ~alarm_rise |=> ~flag_q)
        else $error("write-one did not clear flag");
endmodule : srtc_top

/* File: src/srtc_pkg.sv */
// Purpose: Constants for the seconds clock with alarm and trim
// Assumes: APB with 32-bit data, one register per word index
// Notes:   Byte address of a register is four times its index
package srtc_pkg;
    // ========================================
    // Register indices (byte address = index * 4)
    localparam logic [15:0] IDX_SECURITY   = 16'h4008;
    localparam logic [15:0] IDX_INT_STATUS = 16'h4011;
    localparam logic [15:0] IDX_INT_MASK   = 16'h4019;
    localparam logic [15:0] IDX_TAMPER_TAG = 16'h4020;
    localparam logic [15:0] IDX_SECS_HIGH  = 16'h4021;
    localparam logic [15:0] IDX_SECS_LOW   = 16'h4022;
    localparam logic [15:0] IDX_ALARM_HIGH = 16'h4023;
    localparam logic [15:0] IDX_ALARM_LOW  = 16'h4024;
    localparam logic [15:0] IDX_CONTROL    = 16'h4025;
    localparam logic [15:0] IDX_FREQ_CORR  = 16'h4026;

    // ========================================
    // Field positions
    localparam int BIT_TIME_SET   = 15;
    localparam int BIT_SYNC_BUSY  = 14;
    localparam int BIT_ALARM_ARM  = 10;
    localparam int BIT_ALARM_FLAG = 2;
    localparam int CORR_W         = 10;

    // ========================================
    // Reset values
    localparam logic [31:0] SECS_RST   = 32'h0000_0000;
    localparam logic [31:0] ALARM_RST  = 32'h0000_0000;
    localparam logic [15:0] TAG_RST    = 16'h0000;
    localparam logic [9:0]  CORR_RST   = 10'h000;
    localparam logic        MASK_RST   = 1'b1;
    // Arbitrary nonzero seed for the tag generator
    localparam logic [15:0] LFSR_SEED  = 16'hace1;
    // Arbitrary unlock code for the security register
    localparam logic [15:0] UNLOCK_CODE = 16'h5a5a;

    // ========================================
    // Timing: trim works in 1/64 of an oscillator cycle
    localparam int          OSC_HZ       = 32768;
    localparam int          FRAC_BITS    = 6;
    localparam logic [22:0] OSC_STEP     = 23'h000040;
    localparam logic [22:0] NOMINAL_UNITS =
        23'(OSC_HZ * (1 << FRAC_BITS));
    localparam int          HOUR_S       = 3600;
    localparam logic [11:0] HOUR_LAST    = 12'(HOUR_S - 1);
    localparam logic [3:0]  MAX_UPDATES  = 4'h8;
endpackage : srtc_pkg

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the seconds clock with alarm and trim
// Assumes: Bench drives osc_in itself, one rise per two pclk cycles
// Notes:   Trim at its most negative value keeps one second short
`timescale 1ns/1ps

module tb_top;
    // ========================================
    // Signals and bookkeeping
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        osc_in;
    logic        pwr_sleep;
    logic        pwr_off;
    logic        alarm_irq;
    logic        wake_req;
    logic        on_req;
    int          fails;
    int          check_count;
    int          cyc;
    int          rises;
    int          wake_cnt;
    int          on_cnt;
    logic [31:0] rdata;
    logic        err;
    logic [31:0] secs_exp;
    logic [15:0] tag_prev;
    logic [15:0] val;

    localparam logic [15:0] RIDX [9] = '{srtc_pkg::IDX_TAMPER_TAG,
        srtc_pkg::IDX_SECS_HIGH, srtc_pkg::IDX_SECS_LOW,
        srtc_pkg::IDX_ALARM_HIGH, srtc_pkg::IDX_ALARM_LOW,
        srtc_pkg::IDX_CONTROL, srtc_pkg::IDX_FREQ_CORR,
        srtc_pkg::IDX_INT_STATUS, srtc_pkg::IDX_INT_MASK};
    localparam logic [15:0] RMSK [9] = '{16'hffff, 16'hffff, 16'hffff,
        16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0004, 16'h0004};
    localparam logic [15:0] REXP [9] = '{16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0004};

    srtc_top i_srtc_top (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .osc_in    (osc_in),
        .pwr_sleep (pwr_sleep),
        .pwr_off   (pwr_off),
        .alarm_irq (alarm_irq),
        .wake_req  (wake_req),
        .on_req    (on_req)
    );

    // ========================================
    // Clock, pulse monitor and hang guard
    always #2.5 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc++;
        if (wake_req === 1'b1) wake_cnt++;
        if (on_req === 1'b1) on_cnt++;
        if (cyc >= 80000) begin
            fails++;
            results();
        end
    end

    // ========================================
    // Tasks and expectation functions
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [15:0] idx,
                       input logic [15:0] data);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {16'h0000, data};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic osc_pulse(input int n);
        repeat (n) begin
            @(posedge pclk);
            osc_in <= 1'b1;
            @(posedge pclk);
            osc_in <= 1'b0;
            rises++;
        end
    endtask : osc_pulse

    // Waits out the busy bit so that no write lands during a sync
    task automatic wr_sync(input logic [15:0] idx, input logic [15:0] data);
        apb(1'b1, idx, data);
        osc_pulse(1);
        apb(1'b0, srtc_pkg::IDX_CONTROL, 16'h0000);
        check(rdata[14], 1'b0);
    endtask : wr_sync

    function automatic int osc_per_sec(input logic [9:0] c);
        int lim;
        lim = 2097152 + int'($signed(c));
        return (lim + 63) / 64;
    endfunction : osc_per_sec

    task automatic results;
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // ========================================
    // Main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h00000;
        pwdata = 32'h0000_0000;
        osc_in = 1'b0;
        pwr_sleep = 1'b0;
        pwr_off = 1'b0;
        void'($urandom(32'h0c6a));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (RIDX[i]) begin
            apb(1'b0, RIDX[i], 16'h0000);
            check(rdata & RMSK[i], REXP[i]);
        end
        apb(1'b1, srtc_pkg::IDX_TAMPER_TAG, 16'h1234);
        apb(1'b0, srtc_pkg::IDX_TAMPER_TAG, 16'h0000);
        check(rdata, 32'h0000_0000);
        apb(1'b0, 16'h4001, 16'h0000);
        check({rdata[30:0], err}, {31'h0, 1'b1});
        // Trim is locked until the key is written
        wr_sync(srtc_pkg::IDX_FREQ_CORR, 16'h0200);
        apb(1'b0, srtc_pkg::IDX_FREQ_CORR, 16'h0000);
        check(rdata, 32'h0000_0000);
        wr_sync(srtc_pkg::IDX_SECURITY, srtc_pkg::UNLOCK_CODE);
        apb(1'b1, srtc_pkg::IDX_FREQ_CORR, 16'h0200);
        apb(1'b0, srtc_pkg::IDX_CONTROL, 16'h0000);
        check(rdata[14], 1'b1);
        osc_pulse(1);
        apb(1'b0, srtc_pkg::IDX_CONTROL, 16'h0000);
        check(rdata[14], 1'b0);
        apb(1'b0, srtc_pkg::IDX_FREQ_CORR, 16'h0000);
        check(rdata, 32'h0000_0200);
        // Any other key value locks the trim again
        wr_sync(srtc_pkg::IDX_SECURITY, 16'h0000);
        wr_sync(srtc_pkg::IDX_FREQ_CORR, 16'h0100);
        apb(1'b0, srtc_pkg::IDX_FREQ_CORR, 16'h0000);
        check(rdata, 32'h0000_0200);
        // Nine half-writes in the first hour: the ninth is dropped
        secs_exp = 32'h0000_0000;
        tag_prev = 16'h0000;
        for (int i = 0; i < 9; i++) begin
            val = 16'($urandom_range(16'hffff, 0));
            if (i == 8) val = ~secs_exp[31:16];
            wr_sync((i % 2 == 0) ? srtc_pkg::IDX_SECS_HIGH
                                 : srtc_pkg::IDX_SECS_LOW, val);
            if (i < 8 && i % 2 == 0) secs_exp[31:16] = val;
            if (i < 8 && i % 2 == 1) secs_exp[15:0] = val;
            apb(1'b0, srtc_pkg::IDX_TAMPER_TAG, 16'h0000);
            check(rdata[15:0] !== tag_prev, i < 8);
            tag_prev = rdata[15:0];
        end
        apb(1'b0, srtc_pkg::IDX_CONTROL, 16'h0000);
        check(rdata[15], 1'b1);
        // Counting goes on in the off state; tick follows the trim
        pwr_off <= 1'b1;
        osc_pulse(osc_per_sec(10'h200) - 1 - rises);
        for (int k = 0; k < 2; k++) begin
            apb(1'b0, srtc_pkg::IDX_SECS_HIGH, 16'h0000);
            check(rdata[15:0], secs_exp[31:16]);
            apb(1'b0, srtc_pkg::IDX_SECS_LOW, 16'h0000);
            check(rdata[15:0], secs_exp[15:0]);
            if (k == 0) osc_pulse(1);
            secs_exp = secs_exp + 32'h1;
        end
        secs_exp = secs_exp - 32'h1;
        // Alarm set to the present time while disarmed, then armed
        pwr_off   <= 1'b0;
        pwr_sleep <= 1'b1;
        wr_sync(srtc_pkg::IDX_ALARM_HIGH, secs_exp[31:16]);
        wr_sync(srtc_pkg::IDX_ALARM_LOW, secs_exp[15:0]);
        apb(1'b0, srtc_pkg::IDX_ALARM_HIGH, 16'h0000);
        check(rdata[15:0], secs_exp[31:16]);
        apb(1'b0, srtc_pkg::IDX_ALARM_LOW, 16'h0000);
        check(rdata[15:0], secs_exp[15:0]);
        apb(1'b0, srtc_pkg::IDX_INT_STATUS, 16'h0000);
        check(rdata & 32'h4, 32'h0);
        wr_sync(srtc_pkg::IDX_CONTROL, 16'h0400);
        apb(1'b0, srtc_pkg::IDX_INT_STATUS, 16'h0000);
        check(rdata & 32'h4, 32'h4);
        check({wake_cnt[3:0], on_cnt[3:0]}, 8'h10);
        check(alarm_irq, 1'b0);
        apb(1'b1, srtc_pkg::IDX_INT_MASK, 16'h0000);
        // The write lands on the edge that ends the task; look once settled
        @(negedge pclk);
        check(alarm_irq, 1'b1);
        apb(1'b1, srtc_pkg::IDX_INT_STATUS, 16'h0004);
        @(negedge pclk);
        check(alarm_irq, 1'b0);
        apb(1'b0, srtc_pkg::IDX_INT_STATUS, 16'h0000);
        check(rdata & 32'h4, 32'h0);
        wr_sync(srtc_pkg::IDX_CONTROL, 16'h0000);
        pwr_sleep <= 1'b0;
        pwr_off   <= 1'b1;
        wr_sync(srtc_pkg::IDX_CONTROL, 16'h0400);
        check({wake_cnt[3:0], on_cnt[3:0]}, 8'h11);
        apb(1'b0, srtc_pkg::IDX_CONTROL, 16'h0000);
        check(rdata & 32'hc400, 32'h8400);
        results();
    end
endmodule : tb_top
